// ---- alt_defs.svh ----
`ifndef ALT_DEFS_SVH
`define ALT_DEFS_SVH

// Command field codes (four bits between start and stop patterns)
`define ALT_CMD_PRESSURE 4'ha
`define ALT_CMD_TEMPERATURE 4'h9
`define ALT_CMD_CAL_FIRST 4'h5
`define ALT_CMD_CAL_SECOND 4'h6
`define ALT_CMD_CAL_THIRD 4'h3
`define ALT_CMD_CAL_FOURTH 4'h4

// Frame layout inside the serial history
`define ALT_START_BITS 3'h7
`define ALT_STOP_BITS 3'h0
`define ALT_RESET_LEN 21
`define ALT_RESET_PATTERN 21'h155540

// Readout length in serial clocks and result width
`define ALT_READ_CLOCKS 17
`define ALT_WORD_BITS 16

// Calibration store contents, first word in the top bits
`define ALT_CAL_CONTENT 64'h1111_2222_3333_4444

// Longest conversion time and master clock rate
`define ALT_CONV_TIME_US 35000
`define ALT_MCLK_HZ 32768
`define ALT_CONV_MCLK_CYCLES ((`ALT_CONV_TIME_US * `ALT_MCLK_HZ) / 1000000)

`endif

// ---- alt_pkg.sv ----
package alt_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ACK,
      ST_CONV,
      ST_READ
   } alt_state_type;

   typedef struct packed {
      logic [15:0] pressure_sample;
      logic [15:0] temperature_sample;
   } alt_samples_type;

   typedef struct packed {
      alt_state_type fsm;
      logic [1:0] sclk_s;
      logic sclk_p;
      logic [1:0] mclk_s;
      logic mclk_p;
      logic [1:0] din_s;
      alt_samples_type smp_s0;
      alt_samples_type smp_s1;
      logic [20:0] hist;
      logic [4:0] bitcnt;
      logic ack_cnt;
      logic [15:0] conv_cnt;
      logic [15:0] shreg;
      logic is_temp;
      logic dout;
   } alt_regs_type;

endpackage

// ---- alt_readout.sv ----
`timescale 1ns/1ps
`include "alt_defs.svh"

// Overview of operation
// RL1: Sample input and launch output on rising edges
// RL2: Host drives clock, changes data on falling
// RL3: No select; framing comes from input bits
// RL4: Three high start bits precede command
// RL5: Three low stop bits follow command
// RL6: Four-bit command selects conversion or calibration
// RL7: Output rises in last stop bit on conversion
// RL8: Host gives two clocks then holds low
// RL9: Output falls when conversion completes
// RL10: Seventeen clocks shift out sixteen result bits
// RL11: Clock pause keeps the readout bit position
// RL12: Host reads result before next conversion
// RL13: Twenty-one bit pattern resets from any state
// RL14: Six instructions select the output data
// RL15: Four sixteen-bit calibration words, 64 bits stored
// RL16: Conversion yields pressure or temperature sample
// RL17: Host should reset before each conversion
// RL18: Codes, order and reset pattern are parameters; output bit order is fixed MSB first (shreg[15])
// RL19: Sequencer timed by master clock, crossed safely
module alt_readout #(
   parameter logic [3:0] CMD_PRESSURE = `ALT_CMD_PRESSURE,
   parameter logic [3:0] CMD_TEMPERATURE = `ALT_CMD_TEMPERATURE,
   parameter logic [3:0] CMD_CAL_FIRST = `ALT_CMD_CAL_FIRST,
   parameter logic [3:0] CMD_CAL_SECOND = `ALT_CMD_CAL_SECOND,
   parameter logic [3:0] CMD_CAL_THIRD = `ALT_CMD_CAL_THIRD,
   parameter logic [3:0] CMD_CAL_FOURTH = `ALT_CMD_CAL_FOURTH,
   parameter logic [20:0] RESET_PATTERN = `ALT_RESET_PATTERN,
   parameter logic [63:0] CAL_CONTENT = `ALT_CAL_CONTENT,
   parameter logic [15:0] CONV_MCLK_CYCLES = 16'(`ALT_CONV_MCLK_CYCLES)
)(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic serial_bit_clock_in,
   input wire logic serial_in_line_in,
   input wire logic converter_master_clock_in,
   input wire alt_pkg::alt_samples_type samples_in,
   output logic serial_out_line_out,
   output logic conv_busy_out,
   output logic conv_is_temp_out
);

   alt_pkg::alt_regs_type s_q;
   alt_pkg::alt_regs_type s_d;

   logic sclk_rise;
   logic mclk_rise;
   logic [20:0] hist_n;
   logic reset_hit;
   logic frame_hit;
   logic [3:0] cmd;
   logic is_conv_cmd;
   logic is_cal_cmd;
   logic conv_done;
   logic [15:0] cal_word;
   logic [15:0] conv_word;

   assign sclk_rise = s_q.sclk_s[1] & ~s_q.sclk_p; // [RL1]
   assign mclk_rise = s_q.mclk_s[1] & ~s_q.mclk_p; // [RL19]
   assign hist_n = {s_q.hist[19:0], s_q.din_s[1]};
   assign reset_hit = (hist_n == RESET_PATTERN); // [RL13] [RL18]
   assign frame_hit = (hist_n[9:7] == `ALT_START_BITS) && (hist_n[2:0] == `ALT_STOP_BITS); // [RL3] [RL4] [RL5]
   assign cmd = hist_n[6:3]; // [RL6]
   assign is_conv_cmd = (cmd == CMD_PRESSURE) || (cmd == CMD_TEMPERATURE);
   assign is_cal_cmd = (cmd == CMD_CAL_FIRST) || (cmd == CMD_CAL_SECOND)
      || (cmd == CMD_CAL_THIRD) || (cmd == CMD_CAL_FOURTH);
   assign conv_done = (s_q.conv_cnt == CONV_MCLK_CYCLES);

   // Calibration word selection, first word held in the top bits
   always_comb
   begin
      if (cmd == CMD_CAL_FIRST)
      begin
         cal_word = CAL_CONTENT[63:48]; // [RL15]
      end
      else if (cmd == CMD_CAL_SECOND)
      begin
         cal_word = CAL_CONTENT[47:32];
      end
      else if (cmd == CMD_CAL_THIRD)
      begin
         cal_word = CAL_CONTENT[31:16];
      end
      else
      begin
         cal_word = CAL_CONTENT[15:0];
      end
   end

   assign conv_word = s_q.is_temp ? s_q.smp_s1.temperature_sample
      : s_q.smp_s1.pressure_sample; // [RL16]

   always_comb
   begin
      s_d = s_q;
      s_d.sclk_s = {s_q.sclk_s[0], serial_bit_clock_in};
      s_d.sclk_p = s_q.sclk_s[1];
      s_d.mclk_s = {s_q.mclk_s[0], converter_master_clock_in}; // [RL19]
      s_d.mclk_p = s_q.mclk_s[1];
      s_d.din_s = {s_q.din_s[0], serial_in_line_in};
      s_d.smp_s0 = samples_in;
      s_d.smp_s1 = s_q.smp_s0;
      // Conversion timer counts rising master clock edges from the acknowledge
      if (mclk_rise && (s_q.fsm == alt_pkg::ST_ACK || s_q.fsm == alt_pkg::ST_CONV) && !conv_done)
      begin
         s_d.conv_cnt = s_q.conv_cnt + 16'h0001; // [RL19]
      end
      if (sclk_rise)
      begin
         s_d.hist = hist_n; // [RL1]
         if (reset_hit)
         begin
            s_d.fsm = alt_pkg::ST_IDLE; // [RL13]
            s_d.hist = 21'h000000;
            s_d.dout = 1'b0;
            s_d.bitcnt = 5'h00;
         end
         else
         begin
            case (s_q.fsm)
               alt_pkg::ST_IDLE:
               begin
                  if (frame_hit && is_conv_cmd)
                  begin
                     s_d.fsm = alt_pkg::ST_ACK;
                     s_d.dout = 1'b1; // [RL7]
                     s_d.is_temp = (cmd == CMD_TEMPERATURE); // [RL14]
                     s_d.conv_cnt = 16'h0000;
                     s_d.ack_cnt = 1'b0;
                     s_d.hist = 21'h000000;
                  end
                  else if (frame_hit && is_cal_cmd)
                  begin
                     s_d.fsm = alt_pkg::ST_READ; // [RL14]
                     s_d.shreg = cal_word; // [RL15]
                     s_d.bitcnt = 5'h00;
                     s_d.hist = 21'h000000;
                  end
               end
               alt_pkg::ST_ACK:
               begin
                  s_d.ack_cnt = 1'b1;
                  if (s_q.ack_cnt)
                  begin
                     s_d.fsm = alt_pkg::ST_CONV; // [RL8]
                  end
               end
               alt_pkg::ST_READ:
               begin
                  s_d.bitcnt = s_q.bitcnt + 5'h01; // [RL10] [RL11]
                  s_d.dout = s_q.shreg[15]; // [RL1] [RL18]
                  s_d.shreg = {s_q.shreg[14:0], 1'b0};
                  if (s_q.bitcnt == 5'(`ALT_READ_CLOCKS - 1))
                  begin
                     s_d.fsm = alt_pkg::ST_IDLE; // [RL10]
                     s_d.dout = 1'b0;
                  end
               end
               default:
               begin
                  s_d.fsm = s_q.fsm;
               end
            endcase
         end
      end
      else if (s_q.fsm == alt_pkg::ST_CONV && conv_done)
      begin
         s_d.fsm = alt_pkg::ST_READ;
         s_d.dout = 1'b0; // [RL9]
         s_d.shreg = conv_word; // [RL16]
         s_d.bitcnt = 5'h00;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign serial_out_line_out = s_q.dout;
   assign conv_busy_out = (s_q.fsm == alt_pkg::ST_ACK) || (s_q.fsm == alt_pkg::ST_CONV);
   assign conv_is_temp_out = s_q.is_temp;

   property p_ack;
      @(posedge clk_in) disable iff (!rst_n_in)
      sclk_rise && !reset_hit && s_q.fsm == alt_pkg::ST_IDLE && frame_hit && is_conv_cmd
      |=> serial_out_line_out && s_q.fsm == alt_pkg::ST_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("no acknowledge after conversion command"); // [RL7]

   property p_done;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_q.fsm == alt_pkg::ST_CONV && conv_done && !sclk_rise
      |=> !serial_out_line_out && s_q.fsm == alt_pkg::ST_READ && s_q.shreg == $past(conv_word);
   endproperty
   a_done: assert property (p_done) else $error("completion not signalled with result"); // [RL9]

   property p_reset;
      @(posedge clk_in) disable iff (!rst_n_in)
      sclk_rise && reset_hit |=> s_q.fsm == alt_pkg::ST_IDLE && !serial_out_line_out;
   endproperty
   a_reset: assert property (p_reset) else $error("reset pattern did not return to idle"); // [RL13]

   property p_hold;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_q.fsm == alt_pkg::ST_READ && !sclk_rise |=> $stable(serial_out_line_out) && $stable(s_q.bitcnt);
   endproperty
   a_hold: assert property (p_hold) else $error("readout moved without a clock edge"); // [RL11]

   property p_read_len;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_q.fsm == alt_pkg::ST_READ |-> s_q.bitcnt <= 5'h10;
   endproperty
   a_read_len: assert property (p_read_len) else $error("readout ran past seventeen clocks"); // [RL10]

   property p_conv_high;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_q.fsm == alt_pkg::ST_CONV |-> serial_out_line_out && conv_busy_out;
   endproperty
   a_conv_high: assert property (p_conv_high) else $error("output low during conversion"); // [RL9]

   property p_launch;
      @(posedge clk_in) disable iff (!rst_n_in)
      $changed(serial_out_line_out) |-> $past(sclk_rise) || $past(s_q.fsm) == alt_pkg::ST_CONV;
   endproperty
   a_launch: assert property (p_launch) else $error("output changed off a rising edge"); // [RL1]

   property p_cal;
      @(posedge clk_in) disable iff (!rst_n_in)
      sclk_rise && !reset_hit && s_q.fsm == alt_pkg::ST_IDLE && frame_hit && cmd == CMD_CAL_FIRST
      |=> s_q.fsm == alt_pkg::ST_READ && s_q.shreg == CAL_CONTENT[63:48] && !serial_out_line_out;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration word not loaded"); // [RL15]

   property p_two_clocks;
      @(posedge clk_in) disable iff (!rst_n_in)
      s_q.fsm == alt_pkg::ST_ACK && sclk_rise && s_q.ack_cnt && !reset_hit
      |=> s_q.fsm == alt_pkg::ST_CONV;
   endproperty
   a_two_clocks: assert property (p_two_clocks) else $error("conversion wait not entered"); // [RL8]

endmodule

// ---- alt_host_model.sv ----
`timescale 1ns/1ps
module alt_host_model (
   input wire logic dout_in,
   output logic sclk_out,
   output logic din_out
);
   initial
   begin
      sclk_out = 1'b0;
      din_out = 1'b0;
   end
   // Device answers about three system clocks after a rise, so read late in the low phase
   task automatic xfer(input logic b, output logic q);
      din_out = b;
      #390;
      q = dout_in;
      #10;
      sclk_out = 1'b1;
      #400;
      sclk_out = 1'b0;
   endtask
   task automatic frame(input logic [3:0] code);
      logic q;
      repeat (3) xfer(1'b1, q);
      for (int i = 3; i >= 0; i--) xfer(code[i], q);
      repeat (3) xfer(1'b0, q);
   endtask
   task automatic reset_seq(input logic [20:0] pat);
      logic q;
      for (int i = 20; i >= 0; i--) xfer(pat[i], q);
   endtask
endmodule

// ---- alt_readout_tb.sv ----
`timescale 1ns/1ps
module alt_readout_tb;
   localparam logic [20:0] RST_PAT = 21'h155540;
   localparam logic [63:0] CAL = 64'h1111_2222_3333_4444;
   localparam logic [15:0] P_VAL = 16'hc3a5;
   localparam logic [15:0] T_VAL = 16'h5a3d;
   localparam logic [15:0] CAL_CODES = 16'h5634;
   logic clk_in, rst_n_in, mclk, sclk, din, dout, busy, is_temp;
   alt_pkg::alt_samples_type samples;
   int n_mismatch = 0;
   int checks_done = 0;

   alt_readout #(
      .RESET_PATTERN(RST_PAT),
      .CAL_CONTENT(CAL),
      .CONV_MCLK_CYCLES(16'h0004)
   ) i_alt_readout (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .serial_bit_clock_in(sclk),
      .serial_in_line_in(din),
      .converter_master_clock_in(mclk),
      .samples_in(samples),
      .serial_out_line_out(dout),
      .conv_busy_out(busy),
      .conv_is_temp_out(is_temp)
   );

   alt_host_model i_alt_host_model (
      .dout_in(dout),
      .sclk_out(sclk),
      .din_out(din)
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // 17 readout clocks, optionally with a long clock pause mid-word
   task automatic read_word(input logic [15:0] exp, input bit pause);
      logic q;
      logic [15:0] w;
      i_alt_host_model.xfer(1'b0, q);
      chk({15'h0000, q}, 16'h0000);
      for (int i = 15; i >= 0; i--)
      begin
         if (pause && i == 7)
            #6000;
         i_alt_host_model.xfer(1'b0, w[i]);
      end
      chk(w, exp);
      #390;
      chk({15'h0000, dout}, 16'h0000);
      #410;
   endtask

   task automatic cal_read(input logic [3:0] code, input logic [15:0] exp);
      i_alt_host_model.frame(code);
      read_word(exp, 1'b0);
   endtask

   task automatic conv(input logic [3:0] code, input logic [15:0] exp, input logic temp);
      logic q;
      int n;
      i_alt_host_model.reset_seq(RST_PAT);
      i_alt_host_model.frame(code);
      i_alt_host_model.xfer(1'b0, q);
      chk({14'h0000, q, busy}, 16'h0003);
      i_alt_host_model.xfer(1'b0, q);
      n = 0;
      while (dout !== 1'b0 && n < 5000)
      begin
         @(posedge clk_in);
         n++;
      end
      #1;
      chk({15'h0000, n > 800 && n < 1300}, 16'h0001);
      chk({14'h0000, busy, is_temp}, {15'h0000, temp});
      read_word(exp, 1'b1);
   endtask

   task automatic reset_mid();
      logic q;
      i_alt_host_model.frame(4'ha);
      repeat (2) i_alt_host_model.xfer(1'b0, q);
      i_alt_host_model.reset_seq(RST_PAT);
      #390;
      chk({14'h0000, dout, busy}, 16'h0000);
      #410;
      i_alt_host_model.frame(4'hf);
      #390;
      chk({14'h0000, dout, busy}, 16'h0000);
      #410;
      cal_read(4'h5, CAL[63:48]);
   endtask

   initial
   begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end

   initial
   begin
      mclk = 1'b0;
      // Master clock edges stay 1 ns after system clock edges, never on them
      #51;
      forever #15300 mclk = ~mclk;
   end

   initial
   begin
      #3000000;
      n_mismatch++;
      report_and_stop();
   end

   initial
   begin
      rst_n_in = 1'b0;
      samples = {P_VAL, T_VAL};
      repeat (6) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      repeat (4) @(posedge clk_in);
      #1;
      for (int i = 0; i < 4; i++)
         cal_read(CAL_CODES[15 - 4 * i -: 4], CAL[63 - 16 * i -: 16]);
      conv(4'ha, P_VAL, 1'b0);
      conv(4'h9, T_VAL, 1'b1);
      reset_mid();
      report_and_stop();
   end
endmodule
